// [rsi_dev.sv]
// resampler stream end: input fifo, output fifo, start timing, apb regs
//
// Local design decisions: the APB slave port and the register addresses.
module rsi_dev (
  input wire logic pclk,
  input wire logic presetn,
  rsi_if.dev lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  // ****************************************************
  // input fifo
  // ****************************************************
  logic [61:0] in_mem [2**rsi_pkg::IN_AW];
  logic [rsi_pkg::IN_AW:0] in_wp_reg;
  logic [rsi_pkg::IN_AW:0] in_rp_reg;
  logic in_rdy_reg;
  wire [rsi_pkg::IN_AW:0] in_cnt = in_wp_reg - in_rp_reg;
  wire in_full = in_cnt == rsi_pkg::IN_DEPTH;
  wire in_empty = in_cnt == '0;
  // bit 62 is never looked at
  wire srst_word = lnk.in_vld & lnk.in_data[rsi_pkg::SRST_BIT];
  wire in_push = lnk.in_vld & ~srst_word & ~in_full;
  wire in_over = lnk.in_vld & ~srst_word & in_full;
  // ****************************************************
  // output fifo and phase state
  // ****************************************************
  logic [31:0] out_mem [2**rsi_pkg::OUT_AW];
  logic [rsi_pkg::OUT_AW:0] out_wp_reg;
  logic [rsi_pkg::OUT_AW:0] out_rp_reg;
  logic [rsi_pkg::STEP_W-1:0] acc_reg;
  logic [31:0] hist_reg;
  logic en_reg;
  wire [rsi_pkg::OUT_AW:0] out_cnt = out_wp_reg - out_rp_reg;
  wire out_full = out_cnt == rsi_pkg::OUT_DEPTH;
  wire out_empty = out_cnt == '0;
  logic sw_rst_reg;
  wire srst = srst_word | sw_rst_reg;
  wire xfer = en_reg & ~in_empty & ~out_full & ~srst;
  // ready follows the level left after this edge's push and pull
  wire [rsi_pkg::IN_AW:0] in_cnt_next = in_cnt
    + {{rsi_pkg::IN_AW{1'b0}}, in_push} - {{rsi_pkg::IN_AW{1'b0}}, xfer};
  wire [rsi_pkg::IN_AW:0] in_free = rsi_pkg::IN_DEPTH - in_cnt_next;
  wire [61:0] head = in_mem[in_rp_reg[rsi_pkg::IN_AW-1:0]];
  wire [rsi_pkg::STEP_W-1:0] head_step =
    head[rsi_pkg::STEP_HI:rsi_pkg::STEP_LO];
  wire [31:0] head_dat = head[rsi_pkg::DAT_HI:0];
  // ****************************************************
  // output start timing
  // ****************************************************
  rsi_pkg::rsi_out_st_t st_reg;
  rsi_pkg::rsi_out_st_t st_next;
  logic [8:0] dly_reg;
  logic out_vld_reg;
  logic [31:0] out_dat_reg;
  logic [1:0] flags_reg;
  wire go = st_reg == rsi_pkg::RSI_WAIT && dly_reg == rsi_pkg::START_CNT;
  wire active = st_reg == rsi_pkg::RSI_RUN || go;
  wire out_pop = active & ~out_empty & ~srst;
  wire under = out_vld_reg & (flags_reg != 2'h0);
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      rsi_pkg::RSI_IDLE:
        if (lnk.out_rdy)
          st_next = rsi_pkg::RSI_WAIT;
      rsi_pkg::RSI_WAIT:
        if (!lnk.out_rdy)
          st_next = rsi_pkg::RSI_IDLE;
        else if (go)
          st_next = rsi_pkg::RSI_RUN;
      rsi_pkg::RSI_RUN:
        st_next = rsi_pkg::RSI_RUN;
      default:
        st_next = rsi_pkg::RSI_IDLE;
    endcase
    if (srst)
      st_next = rsi_pkg::RSI_IDLE;
  end
  // ****************************************************
  // apb decode
  // ****************************************************
  logic [rsi_pkg::EV_W-1:0] stat_reg;
  logic [rsi_pkg::EV_W-1:0] mask_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  wire acc_ph = psel & penable & ~pready_reg;
  // writes land at the edge that completes the transfer
  wire done = psel & penable & pready_reg;
  wire wr = done & pwrite;
  wire hit_ctrl = paddr == rsi_pkg::CTRL_OFS;
  wire hit_stat = paddr == rsi_pkg::STAT_OFS;
  wire hit_mask = paddr == rsi_pkg::MASK_OFS;
  wire hit_state = paddr == rsi_pkg::STATE_OFS;
  wire hit_phase = paddr == rsi_pkg::PHASE_OFS;
  wire hit_hist = paddr == rsi_pkg::HIST_OFS;
  wire hit = hit_ctrl | hit_stat | hit_mask | hit_state | hit_phase
    | hit_hist;
  wire [31:0] state_word = {16'h0, 1'b0, in_cnt, 1'b0, out_cnt,
    st_reg == rsi_pkg::RSI_RUN};
  wire [31:0] rd_word =
    hit_ctrl ? {31'h0, en_reg} :
    hit_stat ? {29'h0, stat_reg} :
    hit_mask ? {29'h0, mask_reg} :
    hit_state ? state_word :
    hit_phase ? {2'h0, acc_reg} :
    hit_hist ? hist_reg : 32'h0;
  wire [rsi_pkg::EV_W-1:0] ev = {srst, in_over, under};
  wire [rsi_pkg::EV_W-1:0] w1c = (wr & hit_stat) ?
    pwdata[rsi_pkg::EV_W-1:0] : '0;
  // set wins over the write-one clear
  wire [rsi_pkg::EV_W-1:0] stat_next = (stat_reg & ~w1c) | ev;
  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_wp_reg <= '0;
      in_rp_reg <= '0;
      in_rdy_reg <= 1'b0;
      out_wp_reg <= '0;
      out_rp_reg <= '0;
      acc_reg <= '0;
      hist_reg <= '0;
      st_reg <= rsi_pkg::RSI_IDLE;
      dly_reg <= '0;
      out_vld_reg <= 1'b0;
      out_dat_reg <= '0;
      flags_reg <= 2'h3;
    end
    else
    begin
      if (in_push)
        in_wp_reg <= in_wp_reg + 1'b1;
      if (xfer)
        in_rp_reg <= in_rp_reg + 1'b1;
      // ready from the programmable-full level
      in_rdy_reg <= in_free >= rsi_pkg::PFULL_FREE;
      if (srst)
      begin
        acc_reg <= '0;
        hist_reg <= '0;
        out_wp_reg <= '0;
        out_rp_reg <= '0;
      end
      else
      begin
        if (xfer)
        begin
          acc_reg <= acc_reg + head_step;
          hist_reg <= head_dat;
          out_wp_reg <= out_wp_reg + 1'b1;
        end
        if (out_pop)
          out_rp_reg <= out_rp_reg + 1'b1;
      end
      st_reg <= st_next;
      dly_reg <= st_next == rsi_pkg::RSI_WAIT ? dly_reg + 1'b1 : 9'h0;
      out_vld_reg <= st_next == rsi_pkg::RSI_RUN;
      if (out_pop)
        out_dat_reg <= out_mem[out_rp_reg[rsi_pkg::OUT_AW-1:0]];
      flags_reg <= {out_empty, in_empty};
    end
  end
  always_ff @(posedge pclk)
  begin
    if (in_push)
      in_mem[in_wp_reg[rsi_pkg::IN_AW-1:0]] <=
        lnk.in_data[rsi_pkg::STEP_HI:0];
    if (xfer)
      out_mem[out_wp_reg[rsi_pkg::OUT_AW-1:0]] <= head_dat;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
      stat_reg <= '0;
      mask_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= acc_ph;
      pslverr_reg <= acc_ph & ~hit;
      if (acc_ph & ~pwrite)
        prdata_reg <= rd_word;
      if (wr & hit_ctrl)
        en_reg <= pwdata[0];
      sw_rst_reg <= wr & hit_ctrl & pwdata[rsi_pkg::CTRL_RST];
      if (wr & hit_mask)
        mask_reg <= pwdata[rsi_pkg::EV_W-1:0];
      stat_reg <= stat_next;
      irq_reg <= |(stat_next & mask_reg);
    end
  end
  assign lnk.in_rdy = in_rdy_reg;
  assign lnk.out_vld = out_vld_reg;
  assign lnk.out_dat = out_dat_reg;
  assign lnk.out_flags = flags_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
endmodule : rsi_dev

// [rsi_pkg.sv]
// constants shared by both ends of the resampler stream interface
// Summary of operation
// - word: bit63 reset, 61:32 step, 31:0 sample
// - source sends soft reset before sample words
// - soft reset clears phase, output fifo, history
// - input accepts writes until truly full
// - ready drops below 16 free input locations
// - source writes at most 15 after ready drops
// - output starts 500 cycles after output ready
// - fifo empty flags drive two-bit user field
// - empty flag during output means corrupted data
// - output fifo absorbs the domain crossing; here both sides of it run on pclk
// - output fifo deep enough for prefill margin
package rsi_pkg;
  // ****************************************************
  // stream word layout
  // ****************************************************
  localparam int SRST_BIT = 63;
  localparam int STEP_HI = 61;
  localparam int STEP_LO = 32;
  localparam int DAT_HI = 31;
  localparam int STEP_W = 30;
  localparam int DAT_W = 32;
  // ****************************************************
  // buffer sizes and timing
  // ****************************************************
  localparam int IN_AW = 6;
  localparam logic [IN_AW:0] IN_DEPTH = 7'h40;
  localparam logic [IN_AW:0] PFULL_FREE = 7'h10;
  localparam int OUT_AW = 5;
  localparam logic [OUT_AW:0] OUT_DEPTH = 6'h20;
  localparam int START_DLY = 500;
  localparam logic [8:0] START_CNT = 9'(START_DLY);
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0c;
  localparam logic [7:0] PHASE_OFS = 8'h10;
  localparam logic [7:0] HIST_OFS = 8'h14;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int EV_W = 3;
  localparam int EV_UNDER = 0;
  localparam int EV_OVER = 1;
  localparam int EV_SRST = 2;
  typedef enum logic [1:0] {
    RSI_IDLE = 2'b00,
    RSI_WAIT = 2'b01,
    RSI_RUN = 2'b10
  } rsi_out_st_t;
endpackage : rsi_pkg

// [rsi_if.sv]
// stream interface joining the sample source/sink and the resampler
interface rsi_if;
  logic in_vld;
  logic in_rdy;
  logic [63:0] in_data;
  logic out_rdy;
  logic out_vld;
  logic [31:0] out_dat;
  logic [1:0] out_flags;
  modport dev (
    input in_vld,
    output in_rdy,
    input in_data,
    input out_rdy,
    output out_vld,
    output out_dat,
    output out_flags
  );
  modport src (
    output in_vld,
    input in_rdy,
    output in_data,
    output out_rdy,
    input out_vld,
    input out_dat,
    input out_flags
  );
endinterface : rsi_if

// [rsi_src.sv]
// upstream source and downstream sink end of the resampler stream
module rsi_src (
  input wire logic pclk,
  input wire logic presetn,
  rsi_if.src lnk,
  input wire logic usr_start,
  input wire logic usr_vld,
  output logic usr_rdy,
  input wire logic [31:0] usr_dat,
  input wire logic [29:0] usr_step,
  input wire logic usr_sink_en,
  output logic usr_out_vld,
  output logic [31:0] usr_out_dat,
  output logic usr_err
);
  // ****************************************************
  // write side
  // ****************************************************
  logic started_reg;
  logic in_vld_reg;
  logic [63:0] in_data_reg;
  logic [3:0] late_reg;
  logic usr_rdy_reg;
  // soft reset word goes out first
  wire need_rst = usr_start & ~started_reg;
  // at most 15 writes once ready has fallen
  wire room = lnk.in_rdy | (late_reg != 4'hf);
  wire take = started_reg & usr_vld & usr_rdy_reg;
  wire [3:0] late_next = lnk.in_rdy ? 4'h0 :
    late_reg + {3'h0, in_vld_reg & (late_reg != 4'hf)};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      started_reg <= 1'b0;
      in_vld_reg <= 1'b0;
      in_data_reg <= '0;
      late_reg <= '0;
      usr_rdy_reg <= 1'b0;
    end
    else
    begin
      late_reg <= late_next;
      usr_rdy_reg <= started_reg & (lnk.in_rdy | (late_next < 4'he));
      if (!usr_start)
        started_reg <= 1'b0;
      else if (need_rst)
        started_reg <= 1'b1;
      if (need_rst)
      begin
        in_vld_reg <= 1'b1;
        in_data_reg <= {1'b1, 63'h0};
      end
      else
      begin
        in_vld_reg <= take & room;
        in_data_reg <= {2'h0, usr_step, usr_dat};
      end
    end
  end
  // ****************************************************
  // read side
  // ****************************************************
  logic out_rdy_reg;
  logic o_vld_reg;
  logic [31:0] o_dat_reg;
  logic err_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_rdy_reg <= 1'b0;
      o_vld_reg <= 1'b0;
      o_dat_reg <= '0;
      err_reg <= 1'b0;
    end
    else
    begin
      out_rdy_reg <= usr_sink_en;
      o_vld_reg <= lnk.out_vld;
      o_dat_reg <= lnk.out_dat;
      // sticky until sink disabled
      if (!usr_sink_en)
        err_reg <= 1'b0;
      else if (lnk.out_vld && lnk.out_flags != 2'h0)
        err_reg <= 1'b1;
    end
  end
  assign lnk.in_vld = in_vld_reg;
  assign lnk.in_data = in_data_reg;
  assign lnk.out_rdy = out_rdy_reg;
  assign usr_rdy = usr_rdy_reg;
  assign usr_out_vld = o_vld_reg;
  assign usr_out_dat = o_dat_reg;
  assign usr_err = err_reg;
endmodule : rsi_src

// [rsi_monitor.sv]
// concurrent checks on the resampler stream link
module rsi_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_vld,
  input wire logic in_rdy,
  input wire logic [63:0] in_data,
  input wire logic out_rdy,
  input wire logic out_vld,
  input wire logic [31:0] out_dat,
  input wire logic [1:0] out_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // helper counters
  // ****************
  logic [9:0] wait_reg, wait_next;
  logic [4:0] late_reg, late_next;
  logic [2:0] age_reg, age_next;
  logic seen_reg, seen_next;
  wire srst_word = in_vld && in_data[63];
  wire wait_hold = !out_rdy || out_vld || srst_word;
  assign wait_next = wait_hold ? 10'h0 : wait_reg + {9'h0, !(&wait_reg)};
  assign late_next = in_rdy ? 5'h0 : late_reg + {4'h0, in_vld};
  assign age_next = srst_word ? 3'h0 : age_reg + {2'h0, !(&age_reg)};
  assign seen_next = seen_reg || srst_word;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg <= 10'h0;
      late_reg <= 5'h0;
      age_reg <= 3'h7;
      seen_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= wait_next;
      late_reg <= late_next;
      age_reg <= age_next;
      seen_reg <= seen_next;
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence srst_s;
    in_vld && in_data[63];
  endsequence
  sequence idle_s;
    ##[1:4] !out_vld;
  endsequence
  start_early_a: assert property (
    $rose(out_vld) |-> wait_reg == 10'(rsi_pkg::START_DLY + 1))
    else $error("output started off the fixed delay");
  start_late_a: assert property (
    wait_reg == 10'(rsi_pkg::START_DLY + 1) |-> out_vld)
    else $error("output did not start after the fixed delay");
  srst_idle_a: assert property (srst_s |-> idle_s)
    else $error("soft reset left output running");
  valid_solid_a: assert property (
    $fell(out_vld) |-> age_reg <= 3'h4)
    else $error("output valid dropped without soft reset");
  rdy_reset_a: assert property ($rose(presetn) |=> in_rdy)
    else $error("input ready low with empty buffer");
  rdy_fall_a: assert property (
    $fell(in_rdy) |-> $past(in_vld) || $past(in_vld, 2) || $past(in_vld, 3))
    else $error("input ready fell without writes");
  late_writes_a: assert property (late_reg <= 5'hf)
    else $error("too many writes after ready fell");
  srst_first_a: assert property (
    in_vld && !in_data[63] |-> seen_reg)
    else $error("sample written before soft reset");
endmodule : rsi_monitor

// [test_resampler_stream_interface.sv]
// self-checking bench for both ends of the resampler stream
`define CK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("Error at %0t got %h exp %h", $time, g, e); \
    end \
  end
module test_resampler_stream_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, usr_dat, usr_out_dat;
  logic usr_start, usr_vld, usr_rdy, usr_sink_en, usr_out_vld, usr_err;
  logic [29:0] usr_step;
  int n_errors, n_checks, sent, n;
  rsi_if lnk();
  rsi_dev rsi_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  rsi_src rsi_src_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .usr_start(usr_start), .usr_vld(usr_vld), .usr_rdy(usr_rdy),
    .usr_dat(usr_dat), .usr_step(usr_step), .usr_sink_en(usr_sink_en),
    .usr_out_vld(usr_out_vld), .usr_out_dat(usr_out_dat),
    .usr_err(usr_err));
  rsi_monitor rsi_monitor_inst (.pclk(pclk), .presetn(presetn),
    .in_vld(lnk.in_vld), .in_rdy(lnk.in_rdy), .in_data(lnk.in_data),
    .out_rdy(lnk.out_rdy), .out_vld(lnk.out_vld), .out_dat(lnk.out_dat),
    .out_flags(lnk.out_flags));
  // ****************
  // tasks
  // ****************
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++w < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w >= 20)
      n_errors++;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CK(rd, e)
  endtask : rchk
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : wait_cyc
  // a low-to-high step of the start level sends one soft reset word
  task automatic srst;
    @(posedge pclk);
    usr_start <= 1'b0;
    @(posedge pclk);
    usr_start <= 1'b1;
    wait_cyc(8);
  endtask : srst
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end
  // ****************
  // tests
  // ****************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {usr_start, usr_vld, usr_dat, usr_sink_en} = '0;
    usr_step = 30'h3;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_cyc(1);
    `CK(lnk.out_flags, 2'b11)
    rchk(rsi_pkg::STAT_OFS, 32'h0);
    rchk(rsi_pkg::MASK_OFS, 32'h0);
    rchk(rsi_pkg::PHASE_OFS, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CK({er, rd}, 33'h100000000)
    apb(1'b1, rsi_pkg::CTRL_OFS, 32'h0);
    srst();
    rchk(rsi_pkg::STAT_OFS, 32'h4);
    apb(1'b1, rsi_pkg::STAT_OFS, 32'h4);
    $display("reset test done");
    sent = 0;
    usr_vld <= 1'b1;
    usr_dat <= 32'h5a000000;
    repeat (80)
    begin
      @(posedge pclk);
      if (usr_rdy === 1'b1)
      begin
        sent++;
        usr_dat <= 32'h5a000000 + sent;
      end
    end
    usr_vld <= 1'b0;
    wait_cyc(4);
    `CK(lnk.in_rdy, 1'b0)
    `CK(lnk.out_flags[0], 1'b0)
    `CK(sent >= 49 && sent <= 64, 1'b1)
    apb(1'b0, rsi_pkg::STATE_OFS, 32'h0);
    `CK(rd[14:8], 7'(sent))
    rchk(rsi_pkg::STAT_OFS, 32'h0);
    $display("fill test done");
    apb(1'b1, rsi_pkg::MASK_OFS, 32'h1);
    apb(1'b1, rsi_pkg::CTRL_OFS, 32'h1);
    wait_cyc(40);
    @(posedge pclk);
    usr_sink_en <= 1'b1;
    n = 0;
    do
    begin
      wait_cyc(1);
      n++;
    end
    while (usr_out_vld !== 1'b1 && n < 600);
    `CK(n, 503)
    for (int j = 0; j < sent; j++)
    begin
      `CK({usr_out_vld, usr_out_dat}, {1'b1, 32'h5a000000 + j})
      wait_cyc(1);
    end
    wait_cyc(6);
    `CK({usr_err, irq}, 2'b11)
    rchk(rsi_pkg::STAT_OFS, 32'h1);
    rchk(rsi_pkg::PHASE_OFS, 32'(sent * 3));
    rchk(rsi_pkg::HIST_OFS, 32'h5a000000 + 32'(sent - 1));
    apb(1'b1, rsi_pkg::MASK_OFS, 32'h0);
    wait_cyc(3);
    `CK(irq, 1'b0)
    $display("output test done");
    @(posedge pclk);
    usr_sink_en <= 1'b0;
    wait_cyc(3);
    `CK(usr_err, 1'b0)
    srst();
    `CK({lnk.out_vld, lnk.out_flags[1]}, 2'b01)
    `CK(lnk.in_rdy, 1'b1)
    rchk(rsi_pkg::PHASE_OFS, 32'h0);
    rchk(rsi_pkg::HIST_OFS, 32'h0);
    apb(1'b1, rsi_pkg::STAT_OFS, 32'h7);
    rchk(rsi_pkg::STAT_OFS, 32'h0);
    apb(1'b1, rsi_pkg::MASK_OFS, 32'h7);
    wait_cyc(3);
    `CK(irq, 1'b0)
    apb(1'b1, rsi_pkg::CTRL_OFS, 32'h2);
    rchk(rsi_pkg::STAT_OFS, 32'h4);
    `CK(irq, 1'b1)
    $display("soft reset test done");
    complete_run();
  end
endmodule : test_resampler_stream_interface
